// ---- shared/mdf_pkg.sv ----
// Constants for the receive filter, ring pointer and tally register bank.
// Assumes one 125 MHz clock and a byte-wide register port.
//
// Contract
// - Transmit length is 16 bits, split into low and high byte registers.
// - The full programmed length is passed on; long frames are never cut.
// - Ring pages are 256-byte aligned; first/last hold address bits 15..8.
// - If the next page equals the guard page, storing aborts.
// - Packet first page restores the store pointer after a receive error.
// - Live store address readable as two bytes, high byte bits 15..8.
// - Host transfer start: low register bits 7..0, high bits 15..8.
// - Host transfer steps address up and count down by two or one.
// - Host transfer count is 16 bits, low byte and high byte registers.
// - Current host transfer address readable as two bytes.
// - Destination compared with six station bytes, byte0 holds bits 7..0.
// - First destination bit marks a group address.
// - Top six hash bits latched as last destination bit enters.
// - Hash picks filter bit n in byte n/8 bit n mod 8.
// - Three byte tallies count errors and stop at 192.
// - Reading a tally clears it.
// - Alignment tally counts recognised frames with alignment error.
// - Checksum tally counts recognised frames with checksum error.
// - Missed tally counts recognised frames aborted at the guard page, or recognised ones when monitoring.
// - Group frames pass only via hash when group accept is on.
// - Unicast must match station unless accept-any-unicast is set.
// - An alignment error also counts as a checksum error.
package mdf_pkg;
   localparam int unsigned ADDR_W = 5;
   // Register offsets
   localparam logic [4:0] OFS_TX_LEN_LO = 5'h00;
   localparam logic [4:0] OFS_TX_LEN_HI = 5'h01;
   localparam logic [4:0] OFS_RING_FIRST = 5'h02;
   localparam logic [4:0] OFS_RING_LAST = 5'h03;
   localparam logic [4:0] OFS_RING_GUARD = 5'h04;
   localparam logic [4:0] OFS_PKT_FIRST = 5'h05;
   localparam logic [4:0] OFS_LDMA_LO = 5'h06;
   localparam logic [4:0] OFS_LDMA_HI = 5'h07;
   localparam logic [4:0] OFS_XSTART_LO = 5'h08;
   localparam logic [4:0] OFS_XSTART_HI = 5'h09;
   localparam logic [4:0] OFS_XCOUNT_LO = 5'h0A;
   localparam logic [4:0] OFS_XCOUNT_HI = 5'h0B;
   localparam logic [4:0] OFS_XADDR_LO = 5'h0C;
   localparam logic [4:0] OFS_XADDR_HI = 5'h0D;
   localparam logic [4:0] OFS_ALIGN_TALLY = 5'h0E;
   localparam logic [4:0] OFS_CRC_TALLY = 5'h0F;
   localparam logic [4:0] OFS_MISSED_TALLY = 5'h10;
   localparam logic [4:0] OFS_RX_CFG = 5'h11;
   localparam logic [4:0] OFS_STATION0 = 5'h12;
   localparam logic [4:0] OFS_HASH0 = 5'h18;
   // Receive configuration bits
   localparam int unsigned CFG_GROUP_BIT = 3;
   localparam int unsigned CFG_ANY_UNI_BIT = 4;
   localparam int unsigned CFG_MONITOR_BIT = 5;
   // Tally ceiling, checksum, destination length
   localparam logic [7:0] TALLY_MAX = 8'hC0;
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [5:0] DA_LAST_BIT = 6'h2F;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [7:0] PAGE_OFS_ZERO = 8'h00;
   localparam logic [7:0] PAGE_OFS_LAST = 8'hFF;
endpackage

// ---- logic/mdf_regs.sv ----
// Register bank with receive address filter, ring pointers, host transfer
// pointers and tally counters. Assumes all inputs synchronous to clk and
// receive strobes coming from the deserialiser and receive store engine.
`timescale 1ns/1ps
module mdf_regs (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire logic rx_start,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_byte_stored,
   input wire logic rx_end,
   input wire logic rx_crc_err,
   input wire logic rx_align_err,
   input wire logic xfer_step,
   input wire logic xfer_word,
   output logic [15:0] tx_length,
   output logic [15:0] local_dma_addr,
   output logic [15:0] xfer_addr,
   output logic xfer_active,
   output logic rx_addr_match,
   output logic rx_overflow
);

   typedef struct packed {
      logic [7:0] tx_lo;
      logic [7:0] tx_hi;
      logic [15:0] tx_len;
      logic [7:0] first;
      logic [7:0] last;
      logic [7:0] guard;
      logic [7:0] rx_packet_first_page;
      logic [15:0] laddr;
      logic [15:0] xstart;
      logic [15:0] xcount;
      logic [15:0] xaddr;
      logic [47:0] station;
      logic [63:0] hash;
      logic [7:0] align_t;
      logic [7:0] crc_t;
      logic [7:0] miss_t;
      logic [7:0] cfg;
      logic [31:0] crc;
      logic [47:0] da;
      logic [5:0] bitcnt;
      logic in_frame;
      logic da_done;
      logic pass;
      logic overflow;
      logic active;
      logic [7:0] rdata;
   } mdf_state_type;

   mdf_state_type s_reg;
   mdf_state_type s_next;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Page following pg, wrapping at the ring end
   function automatic logic [7:0] next_page(input logic [7:0] pg,
         input logic [7:0] first, input logic [7:0] last);
      logic [7:0] np;
      np = pg + 8'h01;
      next_page = (np == last) ? first : np;
   endfunction

   // Saturating tally increment
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v >= mdf_pkg::TALLY_MAX) ? mdf_pkg::TALLY_MAX
                                          : v + 8'h01;
   endfunction

   logic [4:0] woff;
   logic [4:0] roff;
   logic [31:0] crc_nx;
   logic [47:0] da_full;
   logic [5:0] hidx;
   logic [7:0] np;
   logic [15:0] step;
   logic store_ok;
   logic bad;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      s_next = s_reg;
      woff = reg_addr - mdf_pkg::OFS_STATION0;
      roff = reg_addr - mdf_pkg::OFS_HASH0;
      crc_nx = {s_reg.crc[30:0], 1'b0};
      da_full = s_reg.da;
      hidx = 6'h00;
      np = 8'h00;
      step = xfer_word ? mdf_pkg::WORD_STEP : mdf_pkg::BYTE_STEP;
      store_ok = s_reg.pass && !s_reg.overflow
                 && !s_reg.cfg[mdf_pkg::CFG_MONITOR_BIT];
      bad = rx_crc_err || rx_align_err || !store_ok;
      s_next.rdata = 8'h00;

      // Read path; write-only registers read as zero
      if (rd_en) begin
         case (reg_addr)
            mdf_pkg::OFS_RING_FIRST: s_next.rdata = s_reg.first;
            mdf_pkg::OFS_RING_LAST: s_next.rdata = s_reg.last;
            mdf_pkg::OFS_RING_GUARD: s_next.rdata = s_reg.guard;
            mdf_pkg::OFS_PKT_FIRST: s_next.rdata = s_reg.rx_packet_first_page;
            mdf_pkg::OFS_LDMA_LO: s_next.rdata = s_reg.laddr[7:0];
            mdf_pkg::OFS_LDMA_HI: s_next.rdata = s_reg.laddr[15:8];
            mdf_pkg::OFS_XADDR_LO: s_next.rdata = s_reg.xaddr[7:0];
            mdf_pkg::OFS_XADDR_HI: s_next.rdata = s_reg.xaddr[15:8];
            mdf_pkg::OFS_ALIGN_TALLY: s_next.rdata = s_reg.align_t;
            mdf_pkg::OFS_CRC_TALLY: s_next.rdata = s_reg.crc_t;
            mdf_pkg::OFS_MISSED_TALLY: s_next.rdata = s_reg.miss_t;
            mdf_pkg::OFS_RX_CFG: s_next.rdata = s_reg.cfg;
            default: begin
               if (reg_addr >= mdf_pkg::OFS_HASH0) begin
                  s_next.rdata = s_reg.hash[{roff[2:0], 3'b000} +: 8];
               end else if (reg_addr >= mdf_pkg::OFS_STATION0) begin
                  s_next.rdata = s_reg.station[{woff[2:0], 3'b000} +: 8];
               end
            end
         endcase
         // Clear on read; an increment this cycle still lands below
         if (reg_addr == mdf_pkg::OFS_ALIGN_TALLY) begin
            s_next.align_t = 8'h00;
         end
         if (reg_addr == mdf_pkg::OFS_CRC_TALLY) begin
            s_next.crc_t = 8'h00;
         end
         if (reg_addr == mdf_pkg::OFS_MISSED_TALLY) begin
            s_next.miss_t = 8'h00;
         end
      end

      // Host transfer stepping; count never wraps below zero
      if (xfer_step && s_reg.xcount != 16'h0000) begin
         s_next.xaddr = s_reg.xaddr + step;
         s_next.xcount = (s_reg.xcount < step) ? 16'h0000
                         : s_reg.xcount - step;
      end

      // Frame reception: destination shift, hash, filter, store pointer
      if (rx_start) begin
         s_next.in_frame = 1'b1;
         s_next.bitcnt = 6'h00;
         s_next.crc = mdf_pkg::CRC_INIT;
         s_next.da_done = 1'b0;
         s_next.pass = 1'b0;
         s_next.overflow = 1'b0;
         s_next.laddr = {s_reg.rx_packet_first_page, mdf_pkg::PAGE_OFS_ZERO};
      end else if (s_reg.in_frame) begin
         if (rx_bit_valid && !s_reg.da_done) begin
            // Every destination goes through the checksum generator
            if (s_reg.crc[31] ^ rx_bit) begin
               crc_nx = crc_nx ^ mdf_pkg::CRC_POLY;
            end
            s_next.crc = crc_nx;
            da_full[s_reg.bitcnt] = rx_bit;
            s_next.da = da_full;
            s_next.bitcnt = s_reg.bitcnt + 6'h01;
            if (s_reg.bitcnt == mdf_pkg::DA_LAST_BIT) begin
               s_next.da_done = 1'b1;
               hidx = crc_nx[31:26];
               if (da_full[0]) begin
                  // Group frames rejected unless group accept is on
                  s_next.pass = s_reg.cfg[mdf_pkg::CFG_GROUP_BIT]
                                && s_reg.hash[hidx];
               end else begin
                  s_next.pass = s_reg.cfg[mdf_pkg::CFG_ANY_UNI_BIT]
                     || (da_full == s_reg.station);
               end
            end
         end
         // Store pointer; crossing into the guard page aborts storing
         if (rx_byte_stored && store_ok) begin
            if (s_reg.laddr[7:0] == mdf_pkg::PAGE_OFS_LAST) begin
               np = next_page(s_reg.laddr[15:8], s_reg.first, s_reg.last);
               if (np == s_reg.guard) begin
                  s_next.overflow = 1'b1;
               end else begin
                  s_next.laddr = {np, mdf_pkg::PAGE_OFS_ZERO};
               end
            end else begin
               s_next.laddr = s_reg.laddr + 16'h0001;
            end
         end
         if (rx_end) begin
            s_next.in_frame = 1'b0;
            if (s_reg.pass) begin
               if (rx_align_err) begin
                  s_next.align_t = sat_inc(s_next.align_t);
               end
               // Alignment errors always carry a checksum error too
               if (rx_crc_err || rx_align_err) begin
                  s_next.crc_t = sat_inc(s_next.crc_t);
               end
               if (s_reg.overflow || s_reg.cfg[mdf_pkg::CFG_MONITOR_BIT]) begin
                  s_next.miss_t = sat_inc(s_next.miss_t);
               end
            end
            if (bad) begin
               // Drop the frame: rewind to its first page
               s_next.laddr = {s_reg.rx_packet_first_page, mdf_pkg::PAGE_OFS_ZERO};
            end else begin
               np = (s_reg.laddr[7:0] == mdf_pkg::PAGE_OFS_ZERO)
                    ? s_reg.laddr[15:8]
                    : next_page(s_reg.laddr[15:8], s_reg.first, s_reg.last);
               s_next.rx_packet_first_page = np;
               s_next.laddr = {np, mdf_pkg::PAGE_OFS_ZERO};
            end
         end
      end

      // Write path; last so software wins over pointer updates
      if (wr_en) begin
         case (reg_addr)
            mdf_pkg::OFS_TX_LEN_LO: s_next.tx_lo = wr_data;
            mdf_pkg::OFS_TX_LEN_HI: s_next.tx_hi = wr_data;
            mdf_pkg::OFS_RING_FIRST: s_next.first = wr_data;
            mdf_pkg::OFS_RING_LAST: s_next.last = wr_data;
            mdf_pkg::OFS_RING_GUARD: s_next.guard = wr_data;
            mdf_pkg::OFS_PKT_FIRST: s_next.rx_packet_first_page = wr_data;
            mdf_pkg::OFS_XSTART_LO: s_next.xstart[7:0] = wr_data;
            mdf_pkg::OFS_XSTART_HI: s_next.xstart[15:8] = wr_data;
            mdf_pkg::OFS_XCOUNT_LO: s_next.xcount[7:0] = wr_data;
            mdf_pkg::OFS_XCOUNT_HI: s_next.xcount[15:8] = wr_data;
            mdf_pkg::OFS_RX_CFG: s_next.cfg = wr_data;
            default: begin
               if (reg_addr >= mdf_pkg::OFS_HASH0) begin
                  s_next.hash[{roff[2:0], 3'b000} +: 8] = wr_data;
               end else if (reg_addr >= mdf_pkg::OFS_STATION0) begin
                  s_next.station[{woff[2:0], 3'b000} +: 8] = wr_data;
               end
            end
         endcase
         // A new start address also reloads the running address
         if (reg_addr == mdf_pkg::OFS_XSTART_LO
               || reg_addr == mdf_pkg::OFS_XSTART_HI) begin
            s_next.xaddr = s_next.xstart;
         end
      end
      // Full 16-bit length handed on untouched, however long
      s_next.tx_len = {s_next.tx_hi, s_next.tx_lo};
      // Busy flag registered so the output leaves a flip-flop directly
      s_next.active = (s_next.xcount != 16'h0000);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs are fields of the state register
   assign rd_data = s_reg.rdata;
   assign tx_length = s_reg.tx_len;
   assign local_dma_addr = s_reg.laddr;
   assign xfer_addr = s_reg.xaddr;
   assign xfer_active = s_reg.active;
   assign rx_addr_match = s_reg.pass;
   assign rx_overflow = s_reg.overflow;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_bad_end;
      s_reg.in_frame && !rx_start && rx_end && rx_crc_err && !wr_en;
   endsequence

   sequence s_da_closed;
      s_reg.in_frame && !rx_start && rx_bit_valid && !s_reg.da_done
      && s_reg.bitcnt == mdf_pkg::DA_LAST_BIT;
   endsequence

   property p_tally_cap;
      @(posedge clk) disable iff (!arst_n)
      s_reg.align_t <= mdf_pkg::TALLY_MAX && s_reg.crc_t <= mdf_pkg::TALLY_MAX
      && s_reg.miss_t <= mdf_pkg::TALLY_MAX;
   endproperty
   a_tally_cap: assert property (p_tally_cap)
      else $error("tally above ceiling");

   property p_read_clears;
      @(posedge clk) disable iff (!arst_n)
      rd_en && reg_addr == mdf_pkg::OFS_MISSED_TALLY && !rx_end
      |=> s_reg.miss_t == 8'h00 && rd_data == $past(s_reg.miss_t);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("missed tally not cleared by read");

   property p_align_counts_crc;
      @(posedge clk) disable iff (!arst_n)
      s_reg.in_frame && !rx_start && rx_end && s_reg.pass && rx_align_err
      && !rd_en && s_reg.crc_t < mdf_pkg::TALLY_MAX
      |=> s_reg.crc_t == $past(s_reg.crc_t) + 8'h01;
   endproperty
   a_align_counts_crc: assert property (p_align_counts_crc)
      else $error("alignment error did not count as checksum error");

   property p_restore;
      @(posedge clk) disable iff (!arst_n)
      s_bad_end |=> local_dma_addr == {$past(s_reg.rx_packet_first_page), 8'h00};
   endproperty
   a_restore: assert property (p_restore)
      else $error("store pointer not rewound after error");

   property p_guard;
      @(posedge clk) disable iff (!arst_n)
      s_reg.in_frame && !rx_start && !rx_end && !wr_en && rx_byte_stored
      && store_ok && s_reg.laddr[7:0] == mdf_pkg::PAGE_OFS_LAST
      && next_page(s_reg.laddr[15:8], s_reg.first, s_reg.last) == s_reg.guard
      |=> rx_overflow && $stable(local_dma_addr);
   endproperty
   a_guard: assert property (p_guard)
      else $error("guard page reached without abort");

   property p_word_step;
      @(posedge clk) disable iff (!arst_n)
      xfer_step && xfer_word && s_reg.xcount >= 16'h0002 && !wr_en
      |=> xfer_addr == $past(xfer_addr) + 16'h0002
      && s_reg.xcount == $past(s_reg.xcount) - 16'h0002;
   endproperty
   a_word_step: assert property (p_word_step)
      else $error("word transfer step wrong");

   property p_tx_len;
      @(posedge clk) disable iff (!arst_n)
      wr_en && reg_addr == mdf_pkg::OFS_TX_LEN_HI
      |=> tx_length[15:8] == $past(wr_data)
          ##1 ($stable(tx_length[15:8]) || $past(wr_en));
   endproperty
   a_tx_len: assert property (p_tx_len)
      else $error("transmit length high byte lost");

   property p_group_off;
      @(posedge clk) disable iff (!arst_n)
      s_da_closed ##0 (s_reg.da[0] && !s_reg.cfg[mdf_pkg::CFG_GROUP_BIT])
      |=> !rx_addr_match;
   endproperty
   a_group_off: assert property (p_group_off)
      else $error("group frame accepted with group accept off");

   property p_any_unicast;
      @(posedge clk) disable iff (!arst_n)
      s_da_closed ##0 (!s_reg.da[0] && s_reg.cfg[mdf_pkg::CFG_ANY_UNI_BIT])
      |=> rx_addr_match;
   endproperty
   a_any_unicast: assert property (p_any_unicast)
      else $error("unicast rejected with accept-any set");

   property p_addr_read;
      @(posedge clk) disable iff (!arst_n)
      rd_en && reg_addr == mdf_pkg::OFS_XADDR_HI
      |=> rd_data == $past(xfer_addr[15:8]);
   endproperty
   a_addr_read: assert property (p_addr_read)
      else $error("host transfer address high byte misread");

endmodule

// ---- testbench/mdf_rx_source.sv ----
// Receive path stand-in: frames destination bits, store strobes and status.
// Assumes the bench calls send_frame from one process at a time.
`timescale 1ns/1ps
module mdf_rx_source (
   input wire logic clk,
   output logic rx_start,
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_byte_stored,
   output logic rx_end,
   output logic rx_crc_err,
   output logic rx_align_err
);
   ////////////////////////////////////////////////////////////////////////
   // Idle levels from time zero
   initial begin
      rx_start = 1'b0;
      rx_bit_valid = 1'b0;
      rx_bit = 1'b0;
      rx_byte_stored = 1'b0;
      rx_end = 1'b0;
      rx_crc_err = 1'b0;
      rx_align_err = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One frame: start, 48 bits from bit 0, stores, end with status
   task automatic send_frame(input logic [47:0] da, input int stores,
                             input logic crc, input logic aln);
      @(posedge clk);
      rx_start <= 1'b1;
      for (int i = 0; i < 48; i++) begin
         @(posedge clk);
         rx_start <= 1'b0;
         rx_bit_valid <= 1'b1;
         rx_bit <= da[i]; // Group bit goes first
      end
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~da[47]; // Line is not held once the bits are over
      repeat (2) @(posedge clk);
      repeat (stores) begin
         rx_byte_stored <= 1'b1;
         @(posedge clk);
      end
      rx_byte_stored <= 1'b0;
      rx_end <= 1'b1;
      rx_crc_err <= crc | aln; // Misaligned frame flags checksum
      rx_align_err <= aln;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_crc_err <= 1'b0;
      rx_align_err <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule

// ---- testbench/test_mdf_regs.sv ----
// Self-checking bench for the filter, ring pointer and tally register bank.
// Assumes mdf_pkg and the receive path model are compiled first.
`timescale 1ns/1ps
module test_mdf_regs;
   logic clk, arst_n, wr_en, rd_en, xfer_step, xfer_word;
   logic [4:0] reg_addr;
   logic [7:0] wr_data, rd_data;
   logic rx_start, rx_bit_valid, rx_bit, rx_byte_stored;
   logic rx_end, rx_crc_err, rx_align_err;
   logic [15:0] tx_length, local_dma_addr, xfer_addr;
   logic xfer_active, rx_addr_match, rx_overflow;
   int err_total, check_count, cycles;
   localparam logic [47:0] STATION = 48'h665544332202;
   localparam logic [47:0] OTHER = STATION ^ 48'h010000000000;
   localparam logic [47:0] GROUP_DA = 48'h0A0B0C0D0E01;

   mdf_regs i_mdf_regs (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .rx_start(rx_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_byte_stored(rx_byte_stored), .rx_end(rx_end),
      .rx_crc_err(rx_crc_err), .rx_align_err(rx_align_err),
      .xfer_step(xfer_step), .xfer_word(xfer_word), .tx_length(tx_length),
      .local_dma_addr(local_dma_addr), .xfer_addr(xfer_addr),
      .xfer_active(xfer_active), .rx_addr_match(rx_addr_match),
      .rx_overflow(rx_overflow));
   mdf_rx_source rx_model (.clk(clk), .rx_start(rx_start),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_byte_stored(rx_byte_stored), .rx_end(rx_end),
      .rx_crc_err(rx_crc_err), .rx_align_err(rx_align_err));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the sixth scenario dominates the run length
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers: compare, bus cycles, transfer step, hash
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      reg_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   // Data stand only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk({8'h00, rd_data}, {8'h00, exp});
   endtask
   task automatic step(input logic w);
      @(posedge clk);
      xfer_step <= 1'b1;
      xfer_word <= w;
      @(posedge clk);
      xfer_step <= 1'b0;
      #1;
   endtask
   function automatic logic [5:0] hash_of(input logic [47:0] da);
      logic [31:0] c;
      c = mdf_pkg::CRC_INIT;
      for (int i = 0; i < 48; i++)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? mdf_pkg::CRC_POLY : 32'h0);
      return c[31:26];
   endfunction
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Ring: rewind on error, page advance, wrap into the guard page
   task automatic t_ring;
      for (int k = 0; k < 6; k++)
         reg_wr(mdf_pkg::OFS_STATION0 + 5'(k), STATION[8*k +: 8]);
      reg_wr(mdf_pkg::OFS_RING_FIRST, 8'h41);
      reg_wr(mdf_pkg::OFS_RING_LAST, 8'h44);
      reg_wr(mdf_pkg::OFS_RING_GUARD, 8'h43);
      reg_wr(mdf_pkg::OFS_PKT_FIRST, 8'h41); // Set once
      rx_model.send_frame(STATION, 3, 1'b1, 1'b0);
      chk(local_dma_addr, 16'h4100);
      rx_model.send_frame(STATION, 300, 1'b0, 1'b0);
      chk(local_dma_addr, 16'h4300);
      rd_chk(mdf_pkg::OFS_PKT_FIRST, 8'h43);
      rd_chk(mdf_pkg::OFS_LDMA_LO, 8'h00);
      rd_chk(mdf_pkg::OFS_LDMA_HI, 8'h43);
      reg_wr(mdf_pkg::OFS_RING_GUARD, 8'h41);
      rx_model.send_frame(STATION, 257, 1'b0, 1'b0);
      chk({15'h0, rx_overflow}, 16'h0001);
      rd_chk(mdf_pkg::OFS_MISSED_TALLY, 8'h01);
      rd_chk(mdf_pkg::OFS_CRC_TALLY, 8'h01);
   endtask

   // Lengths and readback; write-only places read as zero
   task automatic t_regs;
      reg_wr(mdf_pkg::OFS_TX_LEN_LO, 8'hDD);
      reg_wr(mdf_pkg::OFS_TX_LEN_HI, 8'h05);
      chk(tx_length, 16'h05DD);
      rd_chk(mdf_pkg::OFS_TX_LEN_HI, 8'h00);
      for (int k = 0; k < 6; k++)
         rd_chk(mdf_pkg::OFS_STATION0 + 5'(k), STATION[8*k +: 8]);
      rd_chk(mdf_pkg::OFS_RING_FIRST, 8'h41);
      rd_chk(mdf_pkg::OFS_RING_LAST, 8'h44);
      rd_chk(mdf_pkg::OFS_RING_GUARD, 8'h41);
   endtask

   // Host transfer: word and byte steps, stop at a zero count
   task automatic t_xfer;
      reg_wr(mdf_pkg::OFS_XSTART_LO, 8'hFE);
      reg_wr(mdf_pkg::OFS_XSTART_HI, 8'h12);
      reg_wr(mdf_pkg::OFS_XCOUNT_LO, 8'h00);
      reg_wr(mdf_pkg::OFS_XCOUNT_HI, 8'h01);
      chk(xfer_addr, 16'h12FE);
      chk({15'h0, xfer_active}, 16'h0001);
      reg_wr(mdf_pkg::OFS_XCOUNT_HI, 8'h00);
      reg_wr(mdf_pkg::OFS_XCOUNT_LO, 8'h03);
      step(1'b1);
      chk(xfer_addr, 16'h1300);
      step(1'b0);
      chk(xfer_addr, 16'h1301);
      chk({15'h0, xfer_active}, 16'h0000);
      step(1'b1);
      chk(xfer_addr, 16'h1301);
      rd_chk(mdf_pkg::OFS_XADDR_LO, 8'h01);
      rd_chk(mdf_pkg::OFS_XADDR_HI, 8'h13);
   endtask

   // Address recognition: station, any unicast, hashed group frames
   task automatic t_filter;
      logic [5:0] h;
      h = hash_of(GROUP_DA);
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h00);
      rx_model.send_frame(STATION, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0001);
      rx_model.send_frame(OTHER, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0000);
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h10);
      rx_model.send_frame(OTHER, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0001);
      for (int k = 0; k < 8; k++)
         reg_wr(mdf_pkg::OFS_HASH0 + 5'(k),
                (k == h[5:3]) ? (8'h01 << h[2:0]) : 8'h00);
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h08);
      rx_model.send_frame(GROUP_DA, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0001);
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h10);
      rx_model.send_frame(GROUP_DA, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0000);
      reg_wr(mdf_pkg::OFS_HASH0 + {2'b00, h[5:3]}, ~(8'h01 << h[2:0]));
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h08);
      rx_model.send_frame(GROUP_DA, 0, 1'b0, 1'b0);
      chk({15'h0, rx_addr_match}, 16'h0000);
   endtask

   // Error tallies count recognised frames only and clear on read
   task automatic t_tally;
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h00);
      rx_model.send_frame(STATION, 0, 1'b1, 1'b0);
      rx_model.send_frame(STATION, 0, 1'b0, 1'b1);
      rx_model.send_frame(OTHER, 0, 1'b1, 1'b1);
      rd_chk(mdf_pkg::OFS_ALIGN_TALLY, 8'h01);
      rd_chk(mdf_pkg::OFS_CRC_TALLY, 8'h02);
      rd_chk(mdf_pkg::OFS_ALIGN_TALLY, 8'h00);
      rd_chk(mdf_pkg::OFS_CRC_TALLY, 8'h00);
   endtask

   // Monitor mode counts recognised frames up to the ceiling
   task automatic t_sat;
      reg_wr(mdf_pkg::OFS_RX_CFG, 8'h20);
      rd_chk(mdf_pkg::OFS_RX_CFG, 8'h20);
      repeat (193) rx_model.send_frame(STATION, 1, 1'b0, 1'b0);
      rd_chk(mdf_pkg::OFS_MISSED_TALLY, 8'hC0);
      rd_chk(mdf_pkg::OFS_MISSED_TALLY, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence; rx_packet_first_page is written once, so the ring goes first
   initial begin
      arst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      reg_addr = 5'h00;
      wr_data = 8'h00;
      xfer_step = 1'b0;
      xfer_word = 1'b0;
      err_total = 0;
      check_count = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rd_chk(mdf_pkg::OFS_HASH0, 8'h00); // Reset value
      t_ring();
      t_regs();
      t_xfer();
      t_filter();
      t_tally();
      t_sat();
      print_verdict();
   end
endmodule
